// *** logic/fifo_host_ctrl.sv ***
`timescale 1ns/1ns
module fifo_host_ctrl
   import fifo_host_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // user command port
   input  wire logic              cmd_valid,
   input  wire logic [1:0]        cmd_op,
   input  wire logic [DATA_W-1:0] cmd_wdata,
   output logic                   cmd_ready,
   output logic                   cmd_done,
   output logic                   cmd_refused,
   output logic [DATA_W-1:0]      rsp_rdata,
   // mode straps seen by the user
   input  wire logic              depth_mode,
   // device pins
   output logic                   push_n,
   output logic                   pop_n,
   output logic                   clear_line_n,
   output logic                   replay_line_n,
   output logic [DATA_W-1:0]      data_in_bus,
   input  wire logic [DATA_W-1:0] data_out_bus,
   input  wire logic              drained_flag,
   input  wire logic              filled_flag,
   input  wire logic              chain_out_or_half_level,
   // synchronised flag copies
   output logic                   drained_seen,
   output logic                   filled_seen,
   output logic                   half_level_seen
);
   typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_RECOVER} state_t;

   // ==========================================
   // pin synchronisers
   // reset to the levels of a cleared device: half high, filled high, drained low,
   // so the first command after reset is not refused on a false filled flag
   localparam logic [DATA_W+2:0] SYNC_IDLE = {1'b1, 1'b1, 1'b0, {DATA_W{1'b0}}};
   logic [DATA_W+2:0] meta_ff, sync_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= SYNC_IDLE;
         sync_ff <= SYNC_IDLE;
      end else begin
         // in depth mode the flag pins carry the board's composite of every device
         meta_ff <= {chain_out_or_half_level, filled_flag, drained_flag, data_out_bus};
         sync_ff <= meta_ff;
      end
   end
   wire logic [DATA_W-1:0] q_s = sync_ff[DATA_W-1:0];
   wire logic drn_s = sync_ff[DATA_W];
   wire logic fil_s = sync_ff[DATA_W+1];
   wire logic hlf_s = sync_ff[DATA_W+2];

   // ==========================================
   // strobe sequencer
   state_t             st_ff, nxt_st;
   op_t                op_ff, nxt_op;
   logic [3:0]         cnt_ff, nxt_cnt;
   logic               push_n_ff, nxt_push_n, pop_n_ff, nxt_pop_n;
   logic               clr_n_ff, nxt_clr_n, rep_n_ff, nxt_rep_n;
   logic [DATA_W-1:0]  din_ff, nxt_din, rd_ff, nxt_rd;
   logic               done_ff, nxt_done, ref_ff, nxt_ref, rdy_ff, nxt_rdy;

   // a command the device would ignore anyway is refused before any strobe moves
   function automatic logic refuse_cmd(op_t op, logic drn, logic fil, logic chained);
      logic nope;
      nope = 1'b0;
      case (op)
         OP_WRITE:  nope = !fil;
         OP_READ:   nope = !drn;
         OP_REPLAY: nope = chained;
         default:   nope = 1'b0;
      endcase
      return nope;
   endfunction

   always_comb begin
      nxt_st     = st_ff;
      nxt_op     = op_ff;
      nxt_cnt    = cnt_ff;
      nxt_push_n = push_n_ff;
      nxt_pop_n  = pop_n_ff;
      nxt_clr_n  = clr_n_ff;
      nxt_rep_n  = rep_n_ff;
      nxt_din    = din_ff;
      nxt_rd     = rd_ff;
      nxt_done   = 1'b0;
      nxt_ref    = 1'b0;
      nxt_rdy    = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            nxt_rdy = 1'b1;
            if (cmd_valid && rdy_ff) begin
               nxt_rdy = 1'b0;
               nxt_op  = op_t'(cmd_op);
               // flag copies lag the pins by up to two cycles; a refusal may be stale
               if (refuse_cmd(op_t'(cmd_op), drn_s, fil_s, depth_mode)) begin
                  nxt_ref = 1'b1;
                  nxt_st  = ST_RECOVER;
                  nxt_cnt = 4'(RECOVERY_CYC);
               end else begin
                  nxt_din = cmd_wdata;
                  nxt_st  = ST_SETUP;
                  nxt_cnt = 4'(SETUP_CYC);   // data set-up before the strobe
               end
            end
         end
         ST_SETUP: begin
            if (cnt_ff > CNT_ONE) begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end else begin
               nxt_st  = ST_PULSE;
               nxt_cnt = 4'(PULSE_CYC);
               case (op_ff)
                  OP_WRITE: nxt_push_n = 1'b0;
                  OP_READ:  nxt_pop_n  = 1'b0;
                  OP_CLEAR: nxt_clr_n  = 1'b0;
                  default:  nxt_rep_n  = 1'b0;
               endcase
            end
         end
         ST_PULSE: begin
            if (cnt_ff > CNT_ONE) begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end else begin
               nxt_st  = ST_HOLD;
               // sampled through the two-stage sync: the word is the pin value two cycles after the read strobe fell, before access time
               nxt_cnt = CNT_ONE + 4'(ACCESS_CYC > PULSE_CYC ? ACCESS_CYC - PULSE_CYC : 0);
            end
         end
         ST_HOLD: begin
            if (cnt_ff > CNT_ONE) begin
               nxt_cnt = cnt_ff - CNT_ONE;
            end else begin
               if (op_ff == OP_READ)
                  nxt_rd = q_s;
               // rising read strobe floats the bus, ending the word
               nxt_push_n = 1'b1;
               nxt_pop_n  = 1'b1;
               nxt_clr_n  = 1'b1;
               nxt_rep_n  = 1'b1;
               nxt_done   = 1'b1;
               nxt_st     = ST_RECOVER;
               nxt_cnt    = 4'(RECOVERY_CYC);
            end
         end
         ST_RECOVER: begin
            if (cnt_ff > CNT_ONE)
               nxt_cnt = cnt_ff - CNT_ONE;
            else
               nxt_st = ST_IDLE;
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff     <= ST_IDLE;
         op_ff     <= OP_WRITE;
         cnt_ff    <= CNT_ZERO;
         push_n_ff <= 1'b1;
         pop_n_ff  <= 1'b1;
         clr_n_ff  <= 1'b1;
         rep_n_ff  <= 1'b1;
         din_ff    <= '0;
         rd_ff     <= '0;
         done_ff   <= 1'b0;
         ref_ff    <= 1'b0;
         rdy_ff    <= 1'b0;
      end else begin
         st_ff     <= nxt_st;
         op_ff     <= nxt_op;
         cnt_ff    <= nxt_cnt;
         push_n_ff <= nxt_push_n;
         pop_n_ff  <= nxt_pop_n;
         clr_n_ff  <= nxt_clr_n;
         rep_n_ff  <= nxt_rep_n;
         din_ff    <= nxt_din;
         rd_ff     <= nxt_rd;
         done_ff   <= nxt_done;
         ref_ff    <= nxt_ref;
         rdy_ff    <= nxt_rdy;
      end
   end

   // ==========================================
   // outputs
   logic drn_q_ff, fil_q_ff, hlf_q_ff;
   logic nxt_drn_q, nxt_fil_q, nxt_hlf_q;
   always_comb begin
      nxt_drn_q = drn_s;
      nxt_fil_q = fil_s;
      // half flag has no meaning when chained; head select and chain links are
      // board straps, depth_mode only tells the host that they are fitted
      nxt_hlf_q = depth_mode ? 1'b1 : hlf_s;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         drn_q_ff <= 1'b0;
         fil_q_ff <= 1'b1;
         hlf_q_ff <= 1'b1;
      end else begin
         drn_q_ff <= nxt_drn_q;
         fil_q_ff <= nxt_fil_q;
         hlf_q_ff <= nxt_hlf_q;
      end
   end
   // one strobe set fans out to every device of a wide stack; device outputs stay apart
   assign push_n          = push_n_ff;
   assign pop_n           = pop_n_ff;
   assign clear_line_n    = clr_n_ff;
   assign replay_line_n   = rep_n_ff;
   assign data_in_bus     = din_ff;
   assign cmd_ready       = rdy_ff;
   assign cmd_done        = done_ff;
   assign cmd_refused     = ref_ff;
   assign rsp_rdata       = rd_ff;
   assign drained_seen    = drn_q_ff;
   assign filled_seen     = fil_q_ff;
   assign half_level_seen = hlf_q_ff;
endmodule

// *** pkg/fifo_host_pkg.sv ***
// What this block and the board around it do
// - width expansion: drive all input controls in parallel, never join outputs.
// - system ties head select low on first device, high on all others.
// - system chains each chain output to the next device's chain input.
// - composite flags assert only when all device flags assert.
// - each system watches filled of its written device, drained of its read one.
// - writer toggles write strobe only while filled is deasserted.
// - host holds read and write strobes high during a replay.
package fifo_host_pkg;
   localparam int          DATA_W        = 9;
   localparam int          DEPTH_WORDS   = 16384;
   localparam int          CLK_PERIOD_NS = 10;
   // strobe and pulse widths, slowest speed grade
   localparam int          PULSE_NS      = 30;
   localparam int          RECOVERY_NS   = 10;
   localparam int          SETUP_NS      = 30;
   localparam int          ACCESS_NS     = 30;
   localparam int          PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RECOVERY_CYC  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  CNT_ONE       = 4'h1;
   localparam logic [3:0]  CNT_ZERO      = 4'h0;
   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_CLEAR, OP_REPLAY} op_t;
endpackage

// *** test/fifo_host_monitor.sv ***
`timescale 1ns/1ns
module fifo_host_monitor
   import fifo_host_pkg::*;
(
   input wire logic              clk_sys, rst_n, cmd_valid, cmd_ready, cmd_done,
   input wire logic              cmd_refused, depth_mode, push_n, pop_n,
   input wire logic              clear_line_n, replay_line_n, half_level_seen,
   input wire logic [1:0]        cmd_op,
   input wire logic [DATA_W-1:0] data_in_bus
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire take = cmd_valid && cmd_ready;
   // ==========
   // assertions
   a_push_width: assert property ($fell(push_n) |-> (!push_n)[*4] ##1 push_n)
      else $error("write strobe width wrong");
   a_pop_width: assert property ($fell(pop_n) |-> (!pop_n)[*4] ##1 pop_n)
      else $error("read strobe width wrong");
   a_push_done: assert property ($rose(push_n) |-> cmd_done)
      else $error("no done at write strobe release");
   a_answer_time: assert property (take |-> (##1 cmd_refused) or (##8 cmd_done))
      else $error("operation not answered in time");
   a_ready_drop: assert property (take |=> (!cmd_ready)[*2])
      else $error("ready stayed high after take");
   a_single_strobe: assert property ($onehot0({!push_n, !pop_n, !clear_line_n, !replay_line_n}))
      else $error("two device strobes low together");
   a_data_hold: assert property (!push_n |-> $stable(data_in_bus))
      else $error("write data moved under strobe");
   a_depth_half: assert property (depth_mode && $past(depth_mode, 2) |-> half_level_seen)
      else $error("half flag seen in depth mode");
   a_replay_refused: assert property (take && cmd_op == OP_REPLAY && depth_mode
      |-> ##1 cmd_refused ##0 replay_line_n [*3])
      else $error("replay not refused in depth mode");
   c_write: cover property (take && cmd_op == OP_WRITE);
   c_refuse: cover property (cmd_refused);
   c_replay: cover property ($fell(replay_line_n));
endmodule
bind fifo_host_ctrl fifo_host_monitor i_fifo_host_monitor (.*);

// *** test/fifo_dev_model.sv ***
`timescale 1ns/1ns
module fifo_dev_model
   import fifo_host_pkg::*;
#(parameter int DEPTH   = DEPTH_WORDS,
  parameter bit CHAINED = 1'b0)
(
   input wire logic               push_n, pop_n, clear_line_n, replay_line_n,
   input wire logic [DATA_W-1:0]  data_in_bus,
   output logic [DATA_W-1:0]      data_out_bus,
   output logic                   drained_flag, filled_flag, chain_out_or_half_level
);
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] q = '0;
   int                wp = 0, rp = 0, cnt = 0;
   bit                rd_go = 0, wr_wait = 0;
   // ==========
   // flags follow the fill count
   assign drained_flag = cnt != 0;
   assign filled_flag = cnt != DEPTH;
   // chained: low while the write strobe is low with the write pointer on the last location
   assign chain_out_or_half_level = CHAINED ? !(wp == DEPTH - 1 && !push_n)
                                            : cnt <= DEPTH / 2;
   // released bus shows the inverse so a stale word never passes
   assign data_out_bus = pop_n ? ~q : q;
   task automatic store();
      mem[wp] = data_in_bus;
      wp = (wp + 1) % DEPTH;
      cnt++;
   endtask
   always @(negedge clear_line_n) begin
      wp = 0;
      rp = 0;
      cnt = 0;
   end
   always @(negedge replay_line_n) if (clear_line_n && !CHAINED) begin
      rp = 0;
      cnt = wp;
   end
   always @(negedge push_n) begin
      wr_wait = !filled_flag;
      if (!wr_wait) store();
      // read already low on an empty buffer: the word flows straight out
      if (!pop_n && !rd_go && cnt == 1) begin
         q = mem[rp];
         rd_go = 1;
      end
   end
   always @(posedge push_n) wr_wait = 0;
   always @(negedge pop_n) begin
      rd_go = drained_flag;
      if (rd_go) q = mem[rp];
   end
   always @(posedge pop_n) if (rd_go) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
      rd_go = 0;
      // a write held low on the full buffer lands once room appears
      if (wr_wait) begin
         store();
         wr_wait = 0;
      end
   end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ns
module testbench
   import fifo_host_pkg::*;
();
   localparam int D = 8;
   logic clk_sys = 0, rst_n = 0, cmd_valid = 0, depth_mode = 0;
   logic [1:0] cmd_op = 0;
   logic [DATA_W-1:0] cmd_wdata = 0, rsp_rdata, data_in_bus, data_out_bus;
   logic cmd_ready, cmd_done, cmd_refused, push_n, pop_n, clear_line_n, replay_line_n;
   logic drained_flag, filled_flag, chain_out_or_half_level;
   logic drained_seen, filled_seen, half_level_seen;
   int errors = 0, checks = 0;
   wire [2:0] flg = {drained_seen, filled_seen, half_level_seen};
   always #5 clk_sys = ~clk_sys;
   fifo_host_ctrl i_fifo_host_ctrl (.*);
   fifo_dev_model #(.DEPTH(D)) i_fifo_dev_model (.*);
   // ==========
   // tasks
   task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic op(logic [1:0] o, logic [DATA_W-1:0] w, logic refuse);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n++ < 50) begin
         @(posedge clk_sys);
         #1;
      end
      cmd_op = o;
      cmd_wdata = w;
      cmd_valid = 1;
      @(posedge clk_sys);
      #1 cmd_valid = 0;
      while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && n++ < 80) begin
         @(posedge clk_sys);
         #1;
      end
      chk("answer", 1'b1, cmd_done | cmd_refused);
      chk("refused", refuse, cmd_refused);
      // flag copies lag the pins by the synchroniser
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic stop_test();
      if (errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      #50000 errors++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 rst_n = 1;
      chk("flags", 3'b011, flg);
      for (int i = 1; i <= D; i++) begin
         op(OP_WRITE, 9'h100 + i, 0);
         chk("flags", {1'b1, i < D, i <= D / 2}, flg);
      end
      op(OP_WRITE, 9'h0ff, 1);
      for (int i = 1; i <= D; i++) begin
         op(OP_READ, 9'h000, 0);
         chk("rdata", 9'h100 + i, rsp_rdata);
         chk("flags", {i < D, 1'b1, D - i <= D / 2}, flg);
      end
      op(OP_READ, 9'h000, 1);
      for (int i = 0; i < 3; i++) op(OP_WRITE, 9'h1a0 + i, 0);
      op(OP_READ, 9'h000, 0);
      op(OP_REPLAY, 9'h000, 0);
      for (int i = 0; i < 3; i++) begin
         op(OP_READ, 9'h000, 0);
         chk("rdata", 9'h1a0 + i, rsp_rdata);
      end
      op(OP_WRITE, 9'h055, 0);
      op(OP_CLEAR, 9'h000, 0);
      chk("flags", 3'b011, flg);
      op(OP_READ, 9'h000, 1);
      depth_mode = 1;
      op(OP_REPLAY, 9'h000, 1);
      chk("flags", 3'b011, flg);
      stop_test();
   end
endmodule
